// file: hw/video_out_defines.svh
`ifndef VIDEO_OUT_DEFINES_SVH
`define VIDEO_OUT_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CTRL    8'h0A
`define IDX_PED     8'h0B
`define IDX_CCORE   8'h0C
`define IDX_CFLINE  8'h0D
`define IDX_CFPIX   8'h0E
`define IDX_BANK0   8'h17
`define IDX_BANK1   8'h27
`define BANK_LEN    8'h06
`define IDX_STATUS  8'h4C

// ==========================================================
// Field layout inside a bank and the control word
`define BOFF_UG     3'h0
`define BOFF_VG     3'h1
`define BOFF_YG     3'h2
`define BOFF_SG     3'h3
`define BOFF_HUE    3'h4
`define BOFF_YOFF   3'h5
`define CTRL_W      17

// ==========================================================
// Reset values and fixed levels
`define UGAIN_RST   11'h100
`define GAIN_RST    10'h100
`define LVL_240     12'h0F0
`define LVL_256     12'h100
`define CORE_T00    12'h010
`define CORE_T01    12'h00C
`define CORE_T10    12'h008
`define CORE_T11    12'h004

// ==========================================================
// Line numbers of the burst-blanking check
`define LINE_P5     10'h005
`define LINE_P6     10'h006
`define LINE_P309   10'h135
`define LINE_M7     10'h007
`define LINE_M258   10'h102
`define LINE_M259   10'h103

// ==========================================================
// Matrix weights and limiter bounds
`define G_KR        12'sh413
`define G_KB        12'sh18E
`define LIM_LO      16'sh0040
`define LIM_HI_N    16'sh03FF
`define LIM_HI_S    16'sh03AC
`define CLIM_N      16'sh01FF
`define CLIM_S      16'sh01C0

`endif

// file: hw/video_out_pkg.sv
package video_out_pkg;

	// ==========================================================
	// Control word, bit 4 passes super blacks
	typedef struct packed {
		logic       ntsc;
		logic       pal_m;
		logic       rgb_out;
		logic [1:0] output_limit_sel;
		logic [1:0] coring_threshold_sel;
		logic [1:0] blank_level_select;
		logic       band_reject_en;
		logic       coring_out_width;
		logic       adaptive_coring_en;
		logic       superblack_pass;
		logic       chroma_coring_en;
		logic       gauss_filter2;
		logic       gauss_lpf_skip;
		logic       demod_skip;
	} ctrl_s;

	typedef struct packed {
		logic [10:0] u_gain;
		logic [9:0]  v_gain;
		logic [9:0]  luma_gain;
		logic [9:0]  sync_gain;
		logic [15:0] hue;
		logic [7:0]  yoff;
	} bank_s;

	typedef struct packed {
		logic [9:0]  luma;
		logic [9:0]  lpf_luma;
		logic [9:0]  ext_blank_level_in;
		logic [9:0]  u_demod;
		logic [9:0]  v_demod;
		logic [9:0]  cb_in;
		logic [9:0]  cr_in;
		logic        burst_gate;
		logic        hblank;
		logic        vblank;
		logic        vid_active;
		logic        line_start;
		logic        fld;
		logic        burst_present;
		logic [9:0]  line_num;
		logic [10:0] pixel_num;
		logic [7:0]  burst_err;
		logic [15:0] sc_phase;
	} video_in_s;

	typedef struct packed {
		logic [9:0] g_y;
		logic [9:0] b_u;
		logic [9:0] r_v;
	} video_out_s;

	typedef enum logic [1:0] {GRAB_IDLE, GRAB_RUN, GRAB_DONE} grab_e;

	typedef struct packed {
		ctrl_s       ctrl;
		logic [7:0]  ped;
		logic [9:0]  ccore_thr;
		logic [9:0]  cf_line;
		logic [10:0] cf_pix;
		bank_s [1:0] bank;
	} regs_s;

	typedef struct packed {
		logic        b_first;
		logic        fld_d;
		logic        frame_bit;
		logic        color_frame_bit;
		logic [7:0]  burst_cap;
		grab_e       grab;
		logic        lstore_we;
		logic        force_simple;
		logic [15:0] phase_offset;
		logic [31:0] prdata;
	} stat_s;

	typedef struct packed {
		logic [11:0]       blank;
		logic [11:0]       p1;
		logic [11:0]       s1;
		logic [11:0]       l2;
		logic [11:0]       cp;
		logic [11:0]       cpp;
		logic [11:0]       l3;
		logic [11:0]       n1;
		logic [11:0]       n2;
		logic [11:0]       l4;
		logic [4:0][11:0]  sd;
		logic [5:0]        hb;
		logic [4:0][9:0]   uh;
		logic [4:0][9:0]   vh;
		logic [9:0]        u2;
		logic [9:0]        v2;
		logic [9:0]        u3;
		logic [9:0]        v3;
		logic [9:0]        u4;
		logic [9:0]        v4;
		logic [13:0]       y5;
		logic [13:0]       u5;
		logic [13:0]       v5;
		video_out_s        vout;
	} pipe_s;

	typedef struct packed {
		regs_s regs;
		stat_s stat;
		pipe_s pipe;
	} st_s;

endpackage : video_out_pkg

// file: hw/video_chroma_luma_output_path.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Frame bit low frames 0/2, high 1/3
// - 625-line PAL frame from bursts 5,6,309
// - PAL-M frame from bursts on 7,258,259
// - Colour-frame bit zero for NTSC, phase for PAL
// - Banked 16-bit hue offset during active video
// - Burst loop error latched each line, readable
// - Bypass bits skip demodulator and Gaussian filter
// - Chroma below coring threshold forced to zero
// - Line grab fills line store, forces simple
// - Clamp pulse samples selected blanking level
// - Negative remainder becomes sync, positive is luma
// - Pedestal subtracted, negatives clipped unless bit set
// - Neighbour difference compared with selected threshold
// - Coring output rounded, bypass truncated, 8/10 bits
// - Quarter-rate band-reject when enabled
// - U gain up to 2047/256 forms B-Y
// - V, luma, sync gains up to 1023/256
// - Sync gain only during blanking, else luma gain
// - G-Y weights for RGB, zero for colour difference
// - 8-bit offset on luma or RGB outputs
// - Limiter code clamps matrix outputs
// - Bank select picks gain, hue, offset set
`include "video_out_defines.svh"

module video_chroma_luma_output_path #(
	parameter int ADDR_W = 12
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_W-1:0]      paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire video_out_pkg::video_in_s vin,
	input  wire logic                   bank_select,
	input  wire logic                   single_line_grab,
	input  wire logic                   pipe_clear,
	output video_out_pkg::video_out_s   vout,
	output logic [15:0]                 phase_offset,
	output logic                        frame_bit,
	output logic                        color_frame_bit,
	output logic                        first_line_store_we,
	output logic                        comb_force_simple
);
	import video_out_pkg::*;

	localparam bank_s BANK_RST = '{u_gain: `UGAIN_RST, v_gain: `GAIN_RST,
		luma_gain: `GAIN_RST, sync_gain: `GAIN_RST, hue: 16'h0000, yoff: 8'h00};

	st_s st;
	st_s next_st;

	// ==========================================================
	// Helpers
	function automatic logic [4:0] bank_dec(input logic [7:0] idx);
		logic [7:0] d0;
		logic [7:0] d1;
		d0 = idx - `IDX_BANK0;
		d1 = idx - `IDX_BANK1;
		if (d0 < `BANK_LEN) bank_dec = {2'b10, d0[2:0]};
		else if (d1 < `BANK_LEN) bank_dec = {2'b11, d1[2:0]};
		else bank_dec = 5'h00;
	endfunction : bank_dec

	function automatic logic [32:0] read_reg(input st_s s, input logic [7:0] idx);
		logic [4:0] bd;
		bank_s      b;
		bd = bank_dec(idx);
		b  = s.regs.bank[bd[3]];
		read_reg = {1'b1, 32'h0000_0000};
		case (idx)
			`IDX_CTRL:   read_reg[31:0] = {15'h0000, s.regs.ctrl};
			`IDX_PED:    read_reg[31:0] = {24'h00_0000, s.regs.ped};
			`IDX_CCORE:  read_reg[31:0] = {22'h00_0000, s.regs.ccore_thr};
			`IDX_CFLINE: read_reg[31:0] = {22'h00_0000, s.regs.cf_line};
			`IDX_CFPIX:  read_reg[31:0] = {21'h00_0000, s.regs.cf_pix};
			`IDX_STATUS: read_reg[31:0] = {21'h00_0000, s.stat.grab == GRAB_RUN,
				s.stat.color_frame_bit, s.stat.frame_bit, s.stat.burst_cap};
			default: begin
				if (!bd[4]) read_reg[32] = 1'b0;
				else case (bd[2:0])
					`BOFF_UG:  read_reg[31:0] = {21'h00_0000, b.u_gain};
					`BOFF_VG:  read_reg[31:0] = {22'h00_0000, b.v_gain};
					`BOFF_YG:  read_reg[31:0] = {22'h00_0000, b.luma_gain};
					`BOFF_SG:  read_reg[31:0] = {22'h00_0000, b.sync_gain};
					`BOFF_HUE: read_reg[31:0] = {16'h0000, b.hue};
					default:   read_reg[31:0] = {24'h00_0000, b.yoff};
				endcase
			end
		endcase
	endfunction : read_reg

	// Demodulation low-pass; taps are all positive so no ringing
	function automatic logic [9:0] gauss(input logic [4:0][9:0] h, input logic f2,
		input logic skip);
		logic signed [14:0] s;
		s = 15'($signed(h[1])) + 15'($signed(h[3]));
		if (f2) s = (s <<< 2) + 15'($signed(h[0])) + 15'($signed(h[4]))
			+ (15'($signed(h[2])) <<< 2) + (15'($signed(h[2])) <<< 1) + 15'sd8;
		else s = s + (15'($signed(h[2])) <<< 1) + 15'sd2;
		if (skip) gauss = h[2];
		else if (f2) gauss = s[13:4];
		else gauss = s[11:2];
	endfunction : gauss

	function automatic logic [9:0] chroma_core(input logic [9:0] c, input logic [9:0] thr,
		input logic en);
		logic [9:0] m;
		m = c[9] ? 10'(-c) : c;
		chroma_core = (en && m < thr) ? 10'h000 : c;
	endfunction : chroma_core

	function automatic logic [9:0] clip(input logic signed [15:0] x,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		if (x < lo) clip = lo[9:0];
		else if (x > hi) clip = hi[9:0];
		else clip = x[9:0];
	endfunction : clip

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [7:0]         idx;
		logic [4:0]         bd;
		logic [32:0]        rd;
		logic               ok;
		logic               pat;
		logic signed [11:0] d;
		logic signed [11:0] e0;
		logic signed [11:0] e1;
		logic signed [11:0] th;
		logic signed [13:0] sm;
		logic signed [12:0] nt;
		logic signed [22:0] py;
		logic signed [21:0] pu;
		logic signed [21:0] pv;
		logic signed [27:0] gt;
		logic signed [15:0] y;
		logic signed [15:0] u;
		logic signed [15:0] v;
		logic signed [15:0] off;
		logic signed [15:0] lo;
		logic signed [15:0] hi;
		logic signed [15:0] cl;
		logic [9:0]         sg;
		bank_s              bk;
		next_st = st;
		idx = paddr[9:2];
		bd  = bank_dec(idx);
		rd  = read_reg(st, idx);
		ok  = rd[32] && (paddr[ADDR_W-1:10] == '0);
		pat = 1'b0;
		bk  = st.regs.bank[bank_select];
		d = 12'sh000; e0 = 12'sh000; e1 = 12'sh000; th = 12'sh000;
		sm = 14'sh0000; nt = 13'sh0000; py = 23'sh00_0000;
		pu = 22'sh00_0000; pv = 22'sh00_0000; gt = 28'sh000_0000;
		y = 16'sh0000; u = 16'sh0000; v = 16'sh0000; off = 16'sh0000;
		lo = 16'sh0000; hi = 16'sh0000; cl = 16'sh0000; sg = 10'h000;

		// ==========================================================
		// Register bus
		if (psel && !penable) next_st.stat.prdata = rd[31:0];
		if (psel && penable && pwrite && ok) begin
			case (idx)
				`IDX_CTRL:   next_st.regs.ctrl = ctrl_s'(pwdata[`CTRL_W-1:0]);
				`IDX_PED:    next_st.regs.ped = pwdata[7:0];
				`IDX_CCORE:  next_st.regs.ccore_thr = pwdata[9:0];
				`IDX_CFLINE: next_st.regs.cf_line = pwdata[9:0];
				`IDX_CFPIX:  next_st.regs.cf_pix = pwdata[10:0];
				default: begin
					if (bd[4]) case (bd[2:0])
						`BOFF_UG:  next_st.regs.bank[bd[3]].u_gain = pwdata[10:0];
						`BOFF_VG:  next_st.regs.bank[bd[3]].v_gain = pwdata[9:0];
						`BOFF_YG:  next_st.regs.bank[bd[3]].luma_gain = pwdata[9:0];
						`BOFF_SG:  next_st.regs.bank[bd[3]].sync_gain = pwdata[9:0];
						`BOFF_HUE: next_st.regs.bank[bd[3]].hue = pwdata[15:0];
						default:   next_st.regs.bank[bd[3]].yoff = pwdata[7:0];
					endcase
				end
			endcase
		end

		// ==========================================================
		// Frame and colour-frame bits
		next_st.stat.fld_d = vin.fld;
		if (st.stat.fld_d && !vin.fld) next_st.stat.frame_bit = !st.stat.frame_bit;
		if (st.regs.ctrl.ntsc) begin
			next_st.stat.color_frame_bit = 1'b0;
			if (vin.line_num == 10'h000 && vin.pixel_num == st.regs.cf_pix)
				next_st.stat.frame_bit = vin.sc_phase[15];
		end else begin
			if (vin.line_num == st.regs.cf_line && vin.pixel_num == st.regs.cf_pix)
				next_st.stat.color_frame_bit = vin.sc_phase[15];
			// A matched pattern forces the bit, otherwise it flywheels
			if (vin.line_start && !st.regs.ctrl.pal_m) begin
				if (vin.line_num == (vin.fld ? `LINE_P6 : `LINE_P5))
					next_st.stat.b_first = vin.burst_present;
				if (vin.line_num == `LINE_P309) begin
					pat = vin.fld ? (st.stat.b_first != vin.burst_present)
						: (st.stat.b_first == vin.burst_present);
					if (pat) next_st.stat.frame_bit = vin.burst_present;
				end
			end else if (vin.line_start) begin
				if (vin.line_num == `LINE_M7) next_st.stat.b_first = vin.burst_present;
				if (vin.line_num == (vin.fld ? `LINE_M259 : `LINE_M258)) begin
					pat = vin.fld ? (st.stat.b_first == vin.burst_present)
						: (st.stat.b_first != vin.burst_present);
					if (pat) next_st.stat.frame_bit = st.stat.b_first;
				end
			end
		end

		// Hue offset only inside active video, so burst locking is untouched
		next_st.stat.phase_offset = vin.vid_active ? bk.hue : 16'h0000;
		if (vin.line_start) next_st.stat.burst_cap = vin.burst_err;

		// ==========================================================
		// Single line grab
		next_st.stat.force_simple = single_line_grab;
		unique case (st.stat.grab)
			GRAB_IDLE: if (single_line_grab && vin.line_start) begin
				next_st.stat.grab = GRAB_RUN;
				next_st.stat.lstore_we = 1'b1;
			end
			GRAB_RUN: if (vin.line_start) begin
				next_st.stat.grab = GRAB_DONE;
				next_st.stat.lstore_we = 1'b0;
			end
			GRAB_DONE: if (!single_line_grab) next_st.stat.grab = GRAB_IDLE;
			default: begin
				next_st.stat.grab = GRAB_IDLE;
				next_st.stat.lstore_we = 1'b0;
			end
		endcase

		// ==========================================================
		// Luma: clamp, pedestal, adaptive coring, band reject
		if (vin.burst_gate) unique case (st.regs.ctrl.blank_level_select)
			2'b00: next_st.pipe.blank = `LVL_240;
			2'b01: next_st.pipe.blank = `LVL_256;
			2'b10: next_st.pipe.blank = {2'b00, vin.ext_blank_level_in};
			2'b11: next_st.pipe.blank = {2'b00, vin.lpf_luma};
		endcase
		d = $signed({2'b00, vin.luma}) - $signed(st.pipe.blank);
		next_st.pipe.p1 = d[11] ? 12'h000 : d;
		next_st.pipe.s1 = d[11] ? d : 12'h000;
		d = $signed(st.pipe.p1) - $signed({4'h0, st.regs.ped});
		next_st.pipe.l2 = (d[11] && !st.regs.ctrl.superblack_pass) ? 12'h000 : d;
		next_st.pipe.cp  = st.pipe.l2;
		next_st.pipe.cpp = st.pipe.cp;
		unique case (st.regs.ctrl.coring_threshold_sel)
			2'b00: th = `CORE_T00;
			2'b01: th = `CORE_T01;
			2'b10: th = `CORE_T10;
			2'b11: th = `CORE_T11;
		endcase
		e0 = $signed(st.pipe.l2) - $signed(st.pipe.cp);
		e1 = $signed(st.pipe.cp) - $signed(st.pipe.cpp);
		if (e0 < 0) e0 = -e0;
		if (e1 < 0) e1 = -e1;
		sm = 14'($signed(st.pipe.l2)) + (14'($signed(st.pipe.cp)) <<< 1)
			+ 14'($signed(st.pipe.cpp));
		sm = (sm + (st.regs.ctrl.coring_out_width ? 14'sd8 : 14'sd2)) >>> 2;
		if (!st.regs.ctrl.adaptive_coring_en || e0 >= th || e1 >= th)
			next_st.pipe.l3 = st.regs.ctrl.coring_out_width
				? {st.pipe.cp[11:2], 2'b00} : st.pipe.cp;
		else
			next_st.pipe.l3 = st.regs.ctrl.coring_out_width ? {sm[11:2], 2'b00} : sm[11:0];
		next_st.pipe.n1 = st.pipe.l3;
		next_st.pipe.n2 = st.pipe.n1;
		nt = 13'($signed(st.pipe.l3)) + 13'($signed(st.pipe.n2));
		next_st.pipe.l4 = st.regs.ctrl.band_reject_en ? nt[12:1] : st.pipe.n1;
		next_st.pipe.sd = {st.pipe.sd[3:0], st.pipe.s1};
		next_st.pipe.hb = {st.pipe.hb[4:0], vin.hblank | vin.vblank};

		// ==========================================================
		// Chroma: source select, low-pass, coring, delay
		next_st.pipe.uh = {st.pipe.uh[3:0], st.regs.ctrl.demod_skip ? vin.cb_in : vin.u_demod};
		next_st.pipe.vh = {st.pipe.vh[3:0], st.regs.ctrl.demod_skip ? vin.cr_in : vin.v_demod};
		next_st.pipe.u2 = gauss(st.pipe.uh, st.regs.ctrl.gauss_filter2, st.regs.ctrl.gauss_lpf_skip);
		next_st.pipe.v2 = gauss(st.pipe.vh, st.regs.ctrl.gauss_filter2, st.regs.ctrl.gauss_lpf_skip);
		next_st.pipe.u3 = chroma_core(st.pipe.u2, st.regs.ccore_thr, st.regs.ctrl.chroma_coring_en);
		next_st.pipe.v3 = chroma_core(st.pipe.v2, st.regs.ccore_thr, st.regs.ctrl.chroma_coring_en);
		next_st.pipe.u4 = st.pipe.u3;
		next_st.pipe.v4 = st.pipe.v3;

		// ==========================================================
		// Matrix gains
		sg = st.pipe.hb[5] ? bk.sync_gain : bk.luma_gain;
		py = 23'($signed(st.pipe.l4) * $signed({1'b0, bk.luma_gain}))
			+ 23'($signed(st.pipe.sd[4]) * $signed({1'b0, sg}));
		pu = $signed(st.pipe.u4) * $signed({1'b0, bk.u_gain});
		pv = $signed(st.pipe.v4) * $signed({1'b0, bk.v_gain});
		next_st.pipe.y5 = py[21:8];
		next_st.pipe.u5 = pu[21:8];
		next_st.pipe.v5 = pv[21:8];

		// Output stage: G-Y weights, offset, limiter
		y   = 16'($signed(st.pipe.y5));
		u   = 16'($signed(st.pipe.u5));
		v   = 16'($signed(st.pipe.v5));
		off = $signed({8'h00, bk.yoff});
		lo  = st.regs.ctrl.output_limit_sel[1] ? `LIM_LO : 16'sh0000;
		hi  = st.regs.ctrl.output_limit_sel[1] ? `LIM_HI_S : `LIM_HI_N;
		cl  = st.regs.ctrl.output_limit_sel[1] ? `CLIM_S : `CLIM_N;
		if (st.regs.ctrl.rgb_out) begin
			gt = `G_KR * v + `G_KB * u;
			next_st.pipe.vout.g_y = clip(y - 16'(gt >>> 11) + off, lo, hi);
			next_st.pipe.vout.b_u = clip(y + u + off, lo, hi);
			next_st.pipe.vout.r_v = clip(y + v + off, lo, hi);
		end else begin
			next_st.pipe.vout.g_y = clip(y + off, lo, hi);
			next_st.pipe.vout.b_u = st.regs.ctrl.output_limit_sel[0]
				? clip(u, -cl, cl) : clip(u, lo, hi);
			next_st.pipe.vout.r_v = st.regs.ctrl.output_limit_sel[0]
				? clip(v, -cl, cl) : clip(v, lo, hi);
		end
		if (pipe_clear) next_st.pipe = '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.regs.bank[0] <= BANK_RST;
			st.regs.bank[1] <= BANK_RST;
		end else begin
			st <= next_st;
		end
	end

	assign prdata              = st.stat.prdata;
	assign pready              = 1'b1;
	// Unmapped accesses are ignored rather than errored
	assign pslverr             = 1'b0;
	assign vout                = st.pipe.vout;
	assign phase_offset        = st.stat.phase_offset;
	assign frame_bit           = st.stat.frame_bit;
	assign color_frame_bit     = st.stat.color_frame_bit;
	assign first_line_store_we = st.stat.lstore_we;
	assign comb_force_simple   = st.stat.force_simple;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_frame_625;
		vin.line_start && !st.regs.ctrl.ntsc && !st.regs.ctrl.pal_m && !vin.fld
		&& vin.line_num == `LINE_P309 && vin.burst_present == st.stat.b_first
		|=> frame_bit == $past(vin.burst_present);
	endproperty
	a_frame_625: assert property (p_frame_625) else $error("625 frame bit wrong");

	property p_frame_m;
		vin.line_start && !st.regs.ctrl.ntsc && st.regs.ctrl.pal_m && !vin.fld
		&& vin.line_num == `LINE_M258 && vin.burst_present != st.stat.b_first
		|=> frame_bit == $past(st.stat.b_first);
	endproperty
	a_frame_m: assert property (p_frame_m) else $error("PAL-M frame bit wrong");

	property p_cf_ntsc;
		st.regs.ctrl.ntsc |=> !color_frame_bit;
	endproperty
	a_cf_ntsc: assert property (p_cf_ntsc) else $error("colour frame set in NTSC");

	property p_hue;
		!vin.vid_active ##1 vin.vid_active && bank_select
		|-> phase_offset == 16'h0000 ##1 phase_offset == $past(st.regs.bank[1].hue);
	endproperty
	a_hue: assert property (p_hue) else $error("hue offset wrong");

	property p_burst_cap;
		vin.line_start |=> st.stat.burst_cap == $past(vin.burst_err);
	endproperty
	a_burst_cap: assert property (p_burst_cap) else $error("burst error not captured");

	property p_grab;
		st.stat.grab == GRAB_IDLE && single_line_grab && vin.line_start
		|=> first_line_store_we && comb_force_simple;
	endproperty
	a_grab: assert property (p_grab) else $error("line grab not started");

	property p_clamp;
		vin.burst_gate && !pipe_clear && st.regs.ctrl.blank_level_select == 2'b01
		|=> st.pipe.blank == `LVL_256;
	endproperty
	a_clamp: assert property (p_clamp) else $error("blank level not 256");

	property p_limit;
		$past(st.regs.ctrl.output_limit_sel) == 2'b10 && !$past(pipe_clear)
		|-> vout.g_y >= 10'h040 && vout.g_y <= 10'h3AC;
	endproperty
	a_limit: assert property (p_limit) else $error("limiter range broken");

endmodule : video_chroma_luma_output_path

// file: sim/video_sink.sv
`timescale 1ns/1ps
// ==========================================================
// Downstream sink: captures each output word, switches banks in blanking
module video_sink
	import video_out_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire video_out_s  vout,
	input  wire logic        vid_active,
	input  wire logic        bank_req,
	output logic             bank_select,
	output video_out_s       seen
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen        <= '0;
			bank_select <= 1'b0;
		end else begin
			seen <= vout;
			// Switching mid-line would tear the picture
			if (!vid_active) bank_select <= bank_req;
		end
	end
endmodule : video_sink

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "video_out_defines.svh"
module testbench;
	import video_out_pkg::*;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic        bank_req = 0;
	logic        grab = 0;
	logic        clr = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, bank_select, frame_bit, color_frame_bit, we, simple;
	logic [15:0] phase_offset;
	logic [9:0]  exp_clamp [4] = '{10'd260, 10'd244, 10'd400, 10'd200};
	video_in_s   vin = '0;
	video_out_s  vout, seen;
	int          n_mismatch = 0;
	int          compares = 0;
	int          i;

	initial forever #5 pclk = ~pclk;

	video_chroma_luma_output_path dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .vin(vin),
		.bank_select(bank_select), .single_line_grab(grab), .pipe_clear(clr),
		.vout(vout), .phase_offset(phase_offset), .frame_bit(frame_bit),
		.color_frame_bit(color_frame_bit), .first_line_store_we(we),
		.comb_force_simple(simple));
	video_sink sink (.pclk(pclk), .presetn(presetn), .vout(vout),
		.vid_active(vin.vid_active), .bank_req(bank_req),
		.bank_select(bank_select), .seen(seen));

	task summarize;
		if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask : chk

	// ==========================================================
	// APB master; waits on pready under a bound
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		q = prdata;
		psel <= 0;
		penable <= 0;
		if (k == 16) begin
			n_mismatch++;
			summarize();
		end
	endtask : apb

	task rd(input logic [7:0] idx, input logic [31:0] e, input string n);
		apb(0, idx, 0);
		chk(n, e, q);
	endtask : rd

	task ln(input logic [9:0] l, input logic b);
		@(posedge pclk);
		vin.line_num <= l;
		vin.burst_present <= b;
		vin.line_start <= 1;
		@(posedge pclk);
		vin.line_start <= 0;
		repeat (3) @(posedge pclk);
	endtask : ln

	// Steady luma long enough to flush the 8-stage pipe
	task luma(input logic [9:0] y, input logic [9:0] e, input string n);
		@(posedge pclk);
		vin.luma <= y;
		vin.burst_gate <= 1;
		@(posedge pclk);
		vin.burst_gate <= 0;
		repeat (12) @(posedge pclk);
		chk(n, 32'(e), 32'(seen.g_y));
	endtask : luma

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		rd(`IDX_BANK0, 32'(`UGAIN_RST), "u_gain_rst");
		rd(8'h3F, 0, "unmapped");
		chk("pslverr", 0, 32'(pslverr));
		apb(1, `IDX_STATUS, 32'hFFFFFFFF);
		rd(`IDX_STATUS, 0, "status_ro");
		vin.lpf_luma <= 10'd300;
		vin.ext_blank_level_in <= 10'd100;
		for (i = 0; i < 4; i++) begin
			apb(1, `IDX_CTRL, 32'(i) << 8);
			luma(10'd500, exp_clamp[i], "clamp");
		end
		apb(1, `IDX_CTRL, 0);
		apb(1, `IDX_PED, 10);
		luma(10'd500, 10'd250, "pedestal");
		luma(10'd245, 10'd0, "superblack");
		apb(1, `IDX_PED, 0);
		apb(1, `IDX_BANK0 + 8'h05, 64);
		luma(10'd500, 10'd324, "yoff");
		apb(1, `IDX_BANK0 + 8'h02, 32'h200);
		luma(10'd500, 10'd584, "luma_gain");
		apb(1, `IDX_CTRL, 32'h2000);
		luma(10'd1000, 10'd940, "limit");
		apb(1, `IDX_BANK0, 32'h200);
		vin.u_demod <= 10'd100;
		vin.v_demod <= 10'h3CE;
		vin.cb_in <= 10'd20;
		vin.cr_in <= 10'd30;
		apb(1, `IDX_CTRL, 32'h10E4);
		luma(10'd502, 10'd592, "core_round");
		chk("b_u", 32'd200, 32'(seen.b_u));
		chk("r_v", 32'h3CE, 32'(seen.r_v));
		apb(1, `IDX_CCORE, 25);
		apb(1, `IDX_CTRL, 32'h100B);
		luma(10'd500, 10'd584, "y_cd");
		chk("cb_cored", 0, 32'(seen.b_u));
		chk("cr", 32'd30, 32'(seen.r_v));
		apb(1, `IDX_CTRL, 32'h4000);
		luma(10'd500, 10'd571, "g_rgb");
		chk("b_rgb", 32'd784, 32'(seen.b_u));
		chk("r_rgb", 32'd534, 32'(seen.r_v));
		apb(1, `IDX_BANK0 + 8'h04, 32'h1234);
		apb(1, `IDX_BANK1 + 8'h04, 32'hABCD);
		vin.vid_active <= 1;
		repeat (3) @(posedge pclk);
		chk("hue0", 32'h1234, 32'(phase_offset));
		vin.vid_active <= 0;
		bank_req <= 1;
		repeat (3) @(posedge pclk);
		chk("hue_blank", 0, 32'(phase_offset));
		vin.vid_active <= 1;
		repeat (3) @(posedge pclk);
		chk("hue1", 32'hABCD, 32'(phase_offset));
		vin.vid_active <= 0;
		vin.burst_err <= 8'h5A;
		ln(10'd5, 1);
		ln(10'd309, 1);
		chk("frame_pal", 1, 32'(frame_bit));
		rd(`IDX_STATUS, 32'h15A, "status");
		ln(10'd5, 0);
		ln(10'd309, 0);
		chk("frame_pal", 0, 32'(frame_bit));
		apb(1, `IDX_CTRL, 32'h8000);
		ln(10'd7, 1);
		ln(10'd258, 0);
		chk("frame_m", 1, 32'(frame_bit));
		vin.sc_phase <= 16'h8000;
		ln(10'd0, 0);
		chk("cframe_pal", 1, 32'(color_frame_bit));
		apb(1, `IDX_CTRL, 32'h10000);
		ln(10'd0, 0);
		chk("cframe", 0, 32'(color_frame_bit));
		grab <= 1;
		ln(10'd10, 1);
		chk("grab_we", 1, 32'(we));
		chk("simple", 1, 32'(simple));
		grab <= 0;
		ln(10'd11, 1);
		chk("grab_we", 0, 32'(we));
		chk("simple", 0, 32'(simple));
		clr <= 1;
		repeat (3) @(posedge pclk);
		chk("clear", 0, 32'(seen.g_y));
		clr <= 0;
		summarize();
	end
endmodule : testbench
